//--- bsm_pkg.sv
// constants and types shared by the bridge measurement mode controller
package bsm_pkg;

    // ****************************************************************
    // register map (byte addresses on the apb bus)
    // ****************************************************************
    localparam logic [7:0] OFS_SETUP = 8'h00;
    localparam logic [7:0] OFS_GLOBAL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int SETUP_START_BIT = 0;
    localparam int SETUP_MODE_LSB = 1;
    localparam int SETUP_AZ_BIT = 3;
    localparam int SETUP_CH_LSB = 4;
    localparam int SETUP_RES_LSB = 6;
    localparam int GLOBAL_RCO_BIT = 0;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // ****************************************************************
    // conversion timing, in conversion clock cycles
    // ****************************************************************
    localparam int SAMPLES_DEFAULT = 16;
    localparam int CLKS_PER_SAMPLE = 2;
    localparam int SAMPLE_CLKS = SAMPLES_DEFAULT * CLKS_PER_SAMPLE;
    localparam int RESOLVE_CLKS = 16;

    // ****************************************************************
    // modes, channels, gains, states
    // ****************************************************************
    typedef enum logic [1:0] {
        BSM_HIGH_GAIN_BRIDGE_MODE = 2'h0,
        BSM_WIDE_RANGE_BRIDGE_MODE = 2'h1,
        BSM_TEMPERATURE_RESISTOR_MODE = 2'h2,
        BSM_MODE_RSVD = 2'h3
    } bsm_mode_e;

    localparam logic [1:0] CH_THIRD = 2'h2;
    localparam logic [1:0] GAIN_OFF = 2'h0;
    localparam logic [1:0] GAIN_X2 = 2'h1;
    localparam logic [1:0] GAIN_X5 = 2'h2;
    localparam logic [1:0] GAIN_X10 = 2'h3;

    typedef enum logic [2:0] {
        BSM_OP_IDLE = 3'h1,
        BSM_OP_ACTIVE = 3'h2,
        BSM_OP_COMM = 3'h4
    } bsm_op_e;

    typedef enum logic [2:0] {
        BSM_CV_IDLE = 3'h1,
        BSM_CV_SAMPLE = 3'h2,
        BSM_CV_RESOLVE = 3'h4
    } bsm_cv_e;

endpackage

//--- bsm_sync.sv
// two flip-flop level synchroniser
module bsm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // meta feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

//--- bsm_ctrl.sv
// bridge sensor measurement mode controller with apb registers
// ********************************************************************
// What this block does
// - idle: no conversion, no transfer; controller leaves serial clock still
// - conversion runs from a running clock, external or internal oscillator
// - communication state: analog stages off, no conversion running
// - bridge is powered only while sampling, otherwise unpowered
// - both normal bridge modes close the foot point ground switch
// - channel and mode come from register writes and steer the measurement
// - high gain mode: muxed channel, gain ten, sixty millivolt range
// - wide range mode: muxed channel, gain five, 120 millivolt range
// - temperature mode: series resistor, one of four internal or external, gain two
// - temperature mode only on first or second channel
// - auto-zero rides with another mode and shorts the differential input
// - writing one to the start bit launches a conversion
// - busy line goes high on start, low when result is valid
// - start bit clears itself when the conversion completes
// ********************************************************************
module bsm_ctrl #(
    parameter int ADDR_W = 8,
    parameter int SAMPLE_CLKS = bsm_pkg::SAMPLE_CLKS,
    parameter int RESOLVE_CLKS = bsm_pkg::RESOLVE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_clk,
    input wire logic [15:0] adc_data,
    output logic [2:0] bridge_power,
    output logic foot_switch_on,
    output logic mux_en,
    output logic [1:0] mux_sel,
    output logic diff_short,
    output logic [3:0] res_sel,
    output logic [1:0] gain_sel,
    output logic fs_range_wide,
    output logic analog_en,
    output logic rc_osc_en,
    output logic sdo_level,
    output logic [2:0] op_state
);

    // ****************************************************************
    // apb slave, pclk domain
    // ****************************************************************
    logic [7:0] setup, global_cfg, conv_cfg;
    logic [15:0] result;
    logic start_tgl, done_s, done_seen, done_pulse;
    logic access, wr_now, addr_ok, wr_setup, start_now, next_busy;
    logic [31:0] rd_word;

    assign access = psel && penable && !pready;
    assign wr_now = psel && penable && pready && pwrite;
    assign done_pulse = done_s ^ done_seen;

    always_comb begin
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (8'(paddr))
            bsm_pkg::OFS_SETUP: rd_word = {24'h00_0000, setup};
            bsm_pkg::OFS_GLOBAL: rd_word = {24'h00_0000, global_cfg};
            bsm_pkg::OFS_STATUS: rd_word = {28'h000_0000, op_state, sdo_level};
            bsm_pkg::OFS_RESULT: rd_word = {16'h0000, result};
            default: addr_ok = 1'b0;
        endcase
    end

    // writes to the setup word are refused while a conversion runs, so the
    // latched selection cannot change under the analog path
    assign wr_setup = wr_now && (8'(paddr) == bsm_pkg::OFS_SETUP) && (!sdo_level || done_pulse);
    assign start_now = wr_setup && pwdata[bsm_pkg::SETUP_START_BIT];
    assign next_busy = start_now || (sdo_level && !done_pulse);

    // answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !addr_ok;
            prdata <= (access && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup <= bsm_pkg::SETUP_RST;
        end else if (wr_setup) begin
            setup <= pwdata[7:0];
        end else if (done_pulse) begin
            setup[bsm_pkg::SETUP_START_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_cfg <= bsm_pkg::GLOBAL_RST;
        end else if (wr_now && (8'(paddr) == bsm_pkg::OFS_GLOBAL)) begin
            global_cfg <= pwdata[7:0];
        end
    end

    // selection snapshot, loaded on the same edge as the start toggle and stable until done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cfg <= bsm_pkg::SETUP_RST;
            start_tgl <= 1'b0;
        end else if (start_now) begin
            conv_cfg <= pwdata[7:0];
            start_tgl <= !start_tgl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_level <= 1'b0;
            rc_osc_en <= 1'b0;
        end else begin
            sdo_level <= next_busy;
            rc_osc_en <= next_busy && global_cfg[bsm_pkg::GLOBAL_RCO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_state <= bsm_pkg::BSM_OP_IDLE;
        end else if (next_busy) begin
            op_state <= bsm_pkg::BSM_OP_ACTIVE;
        end else if (psel) begin
            op_state <= bsm_pkg::BSM_OP_COMM;
        end else begin
            op_state <= bsm_pkg::BSM_OP_IDLE;
        end
    end

    // ****************************************************************
    // completion crossing back into pclk
    // ****************************************************************
    logic done_tgl;
    logic [15:0] conv_result;

    bsm_sync #(.WIDTH(1)) u_done_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(done_tgl),
        .q(done_s)
    );

    // conv_result changes on the toggle edge and is then held still for many cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_seen <= 1'b0;
            result <= bsm_pkg::RESULT_RST;
        end else begin
            done_seen <= done_s;
            if (done_pulse) begin
                result <= conv_result;
            end
        end
    end

    // ****************************************************************
    // conversion sequencer, conv_clk domain
    // ****************************************************************
    logic start_s, start_seen, start_pulse, cv_running, path_ok, az;
    logic [7:0] cfg, live_cfg, cnt, next_cnt;
    logic [1:0] ch, rsel;
    bsm_pkg::bsm_mode_e mode;
    bsm_pkg::bsm_cv_e cv_state, next_cv;

    bsm_sync #(.WIDTH(1)) u_start_sync (
        .clk(conv_clk),
        .rst_n(presetn),
        .d(start_tgl),
        .q(start_s)
    );

    assign start_pulse = start_s ^ start_seen;
    // steering loads on the start edge, before cfg holds the new word
    assign live_cfg = (start_pulse && cv_state == bsm_pkg::BSM_CV_IDLE) ? conv_cfg : cfg;
    assign mode = bsm_pkg::bsm_mode_e'(live_cfg[bsm_pkg::SETUP_MODE_LSB +: 2]);
    assign az = live_cfg[bsm_pkg::SETUP_AZ_BIT];
    assign ch = live_cfg[bsm_pkg::SETUP_CH_LSB +: 2];
    assign rsel = live_cfg[bsm_pkg::SETUP_RES_LSB +: 2];
    // unsupported channel codes, reserved mode and temperature on the
    // third channel keep bridge, mux, short, gain and resistor off; analog_en still follows the sequencer
    assign path_ok = (mode != bsm_pkg::BSM_MODE_RSVD) && (ch <= bsm_pkg::CH_THIRD)
        && !(mode == bsm_pkg::BSM_TEMPERATURE_RESISTOR_MODE && ch == bsm_pkg::CH_THIRD);

    always_comb begin
        next_cv = cv_state;
        next_cnt = cnt;
        unique case (cv_state)
            bsm_pkg::BSM_CV_IDLE: begin
                if (start_pulse) begin
                    next_cv = bsm_pkg::BSM_CV_SAMPLE;
                    next_cnt = 8'(SAMPLE_CLKS - 1);
                end
            end
            bsm_pkg::BSM_CV_SAMPLE: begin
                if (cnt == 8'h00) begin
                    next_cv = bsm_pkg::BSM_CV_RESOLVE;
                    next_cnt = 8'(RESOLVE_CLKS - 1);
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            bsm_pkg::BSM_CV_RESOLVE: begin
                if (cnt == 8'h00) begin
                    next_cv = bsm_pkg::BSM_CV_IDLE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: begin
                next_cv = bsm_pkg::BSM_CV_IDLE;
            end
        endcase
    end

    assign cv_running = next_cv != bsm_pkg::BSM_CV_IDLE;

    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            cv_state <= bsm_pkg::BSM_CV_IDLE;
            cnt <= 8'h00;
            start_seen <= 1'b0;
        end else begin
            cv_state <= next_cv;
            cnt <= next_cnt;
            start_seen <= start_s;
        end
    end

    // config snapshot is stable here: it was loaded with the start toggle, two synchroniser stages before start_pulse
    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            cfg <= bsm_pkg::SETUP_RST;
        end else if (start_pulse && cv_state == bsm_pkg::BSM_CV_IDLE) begin
            cfg <= conv_cfg;
        end
    end

    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            done_tgl <= 1'b0;
            conv_result <= 16'h0000;
        end else if (cv_state == bsm_pkg::BSM_CV_RESOLVE && cnt == 8'h00) begin
            done_tgl <= !done_tgl;
            conv_result <= adc_data;
        end
    end

    // ****************************************************************
    // analog steering, registered from the next sequencer state
    // ****************************************************************
    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            bridge_power <= 3'h0;
            foot_switch_on <= 1'b0;
        end else if (next_cv == bsm_pkg::BSM_CV_SAMPLE && path_ok) begin
            bridge_power <= 3'(3'h1 << ch);
            foot_switch_on <= (mode == bsm_pkg::BSM_HIGH_GAIN_BRIDGE_MODE)
                || (mode == bsm_pkg::BSM_WIDE_RANGE_BRIDGE_MODE);
        end else begin
            bridge_power <= 3'h0;
            foot_switch_on <= 1'b0;
        end
    end

    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            analog_en <= 1'b0;
            mux_en <= 1'b0;
            mux_sel <= 2'h0;
            diff_short <= 1'b0;
        end else begin
            analog_en <= cv_running;
            mux_en <= cv_running && path_ok;
            mux_sel <= ch;
            diff_short <= cv_running && path_ok && az;
        end
    end

    always_ff @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            gain_sel <= bsm_pkg::GAIN_OFF;
            fs_range_wide <= 1'b0;
            res_sel <= 4'h0;
        end else if (cv_running && path_ok) begin
            unique case (mode)
                bsm_pkg::BSM_HIGH_GAIN_BRIDGE_MODE: gain_sel <= bsm_pkg::GAIN_X10;
                bsm_pkg::BSM_WIDE_RANGE_BRIDGE_MODE: gain_sel <= bsm_pkg::GAIN_X5;
                bsm_pkg::BSM_TEMPERATURE_RESISTOR_MODE: gain_sel <= bsm_pkg::GAIN_X2;
                bsm_pkg::BSM_MODE_RSVD: gain_sel <= bsm_pkg::GAIN_OFF;
            endcase
            fs_range_wide <= mode == bsm_pkg::BSM_WIDE_RANGE_BRIDGE_MODE;
            res_sel <= (mode == bsm_pkg::BSM_TEMPERATURE_RESISTOR_MODE)
                ? 4'(4'h1 << rsel) : 4'h0;
        end else begin
            gain_sel <= bsm_pkg::GAIN_OFF;
            fs_range_wide <= 1'b0;
            res_sel <= 4'h0;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    start_sets_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_now |=> sdo_level && op_state == bsm_pkg::BSM_OP_ACTIVE)
        else $error("start did not raise busy");
    start_bit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_pulse && !start_now |=> !setup[bsm_pkg::SETUP_START_BIT] && !sdo_level)
        else $error("start bit not cleared on completion");
    idle_no_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_state != bsm_pkg::BSM_OP_ACTIVE |-> !sdo_level && !rc_osc_en)
        else $error("conversion flagged outside active state");
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    bridge_only_sample_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        bridge_power != 3'h0 |-> cv_state == bsm_pkg::BSM_CV_SAMPLE && path_ok)
        else $error("bridge powered outside sampling");
    foot_switch_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        cv_state == bsm_pkg::BSM_CV_SAMPLE && path_ok
        && mode != bsm_pkg::BSM_TEMPERATURE_RESISTOR_MODE |-> foot_switch_on)
        else $error("foot switch open in bridge mode");
    temp_third_ch_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        mode == bsm_pkg::BSM_TEMPERATURE_RESISTOR_MODE && ch == bsm_pkg::CH_THIRD
        |-> bridge_power == 3'h0 && res_sel == 4'h0 && !mux_en)
        else $error("third channel driven in temperature mode");
    gain_mode_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        cv_state != bsm_pkg::BSM_CV_IDLE && path_ok
        && mode == bsm_pkg::BSM_HIGH_GAIN_BRIDGE_MODE |-> gain_sel == bsm_pkg::GAIN_X10
        && !fs_range_wide)
        else $error("high gain mode steering wrong");
    wide_gain_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        cv_state != bsm_pkg::BSM_CV_IDLE && path_ok
        && mode == bsm_pkg::BSM_WIDE_RANGE_BRIDGE_MODE |-> gain_sel == bsm_pkg::GAIN_X5
        && fs_range_wide)
        else $error("wide range mode steering wrong");
    back_to_idle_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        cv_state == bsm_pkg::BSM_CV_RESOLVE && cnt == 8'h00
        |=> cv_state == bsm_pkg::BSM_CV_IDLE && !analog_en && bridge_power == 3'h0)
        else $error("sequencer did not return to idle");
    auto_zero_a: assert property (@(posedge conv_clk) disable iff (!presetn)
        cv_state != bsm_pkg::BSM_CV_IDLE |-> diff_short == (az && path_ok))
        else $error("auto-zero short wrong");

endmodule

//--- bsm_far_model.sv
// far side model: conversion clock source and analog stage answering with a sample count
module bsm_far_model #(
    parameter int PERIOD_NS = 48
) (
    input wire logic presetn,
    input wire logic [2:0] bridge_power,
    input wire logic analog_en,
    output logic conv_clk,
    output logic [15:0] adc_data
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] powered_cnt;

    // free running source, offset so its edges never meet the bus clock edges
    initial begin
        conv_clk = 1'b0;
        #5;
        forever #(PERIOD_NS / 2) conv_clk = ~conv_clk;
    end

    // a sampling window one edge too long or short shows up in the result word
    always @(posedge conv_clk or negedge presetn) begin
        if (!presetn) begin
            powered_cnt <= 8'h00;
        end else if (!analog_en) begin
            powered_cnt <= 8'h00;
        end else if (bridge_power != 3'h0) begin
            powered_cnt <= powered_cnt + 8'h01;
        end
    end

    assign adc_data = {8'h5a, powered_cnt};
endmodule

//--- bsm_ctrl_tb.sv
// self-checking bench for the bridge measurement mode controller
module bsm_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SAMPLES = 4;
    localparam int RESOLVES = 2;

    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic pready, pslverr, rd_err, conv_clk;
    logic [15:0] adc_data;
    logic [2:0] bridge_power, op_state, seen_bp, seen_mux;
    logic foot_switch_on, mux_en, diff_short, fs_range_wide, analog_en, rc_osc_en, sdo_level;
    logic [1:0] mux_sel, gain_sel, seen_gain;
    logic [3:0] res_sel, seen_res;
    logic seen_foot, seen_wide, seen_short;
    int num_errors = 0;
    int samples_checked = 0;
    // high gain, wide+az, temp int, temp ext, temp third ch, reserved, high gain+az third ch
    logic [7:0] setups [7] = '{8'h01, 8'h1b, 8'h95, 8'hc5, 8'h25, 8'h07, 8'h29};
    // {power, foot, gain, wide, short, resistor} seen while sampling
    logic [11:0] steer [7] = '{12'h3c0, 12'h5b0, 12'h444, 12'h248, 12'h000, 12'h000, 12'h9d0};

    bsm_ctrl #(
        .SAMPLE_CLKS(SAMPLES),
        .RESOLVE_CLKS(RESOLVES)
    ) u_bsm_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_clk(conv_clk), .adc_data(adc_data),
        .bridge_power(bridge_power), .foot_switch_on(foot_switch_on), .mux_en(mux_en),
        .mux_sel(mux_sel), .diff_short(diff_short), .res_sel(res_sel),
        .gain_sel(gain_sel), .fs_range_wide(fs_range_wide), .analog_en(analog_en),
        .rc_osc_en(rc_osc_en), .sdo_level(sdo_level), .op_state(op_state)
    );

    bsm_far_model u_bsm_far_model (
        .presetn(presetn), .bridge_power(bridge_power), .analog_en(analog_en),
        .conv_clk(conv_clk), .adc_data(adc_data)
    );

    always #4 pclk = ~pclk;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h0);
        check(what, exp, rd_data);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************************************
    // link side monitor
    // ****************************************************************
    always @(posedge conv_clk) begin
        if (bridge_power != 3'h0) begin
            seen_bp <= seen_bp | bridge_power;
            seen_foot <= foot_switch_on;
            seen_gain <= gain_sel;
            seen_wide <= fs_range_wide;
            seen_short <= diff_short;
            seen_res <= res_sel;
            seen_mux <= {mux_en, mux_sel};
            check("power_busy", 32'h1, {31'h0, sdo_level});
        end
        if (op_state == bsm_pkg::BSM_OP_COMM) begin
            check("analog_comm", 32'h0, {31'h0, analog_en});
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seen_bp = 3'h0;
        // held over several link clock edges so both domains see reset
        repeat (3) @(posedge conv_clk);
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("setup_rst", bsm_pkg::OFS_SETUP, 32'h0);
        rd_chk("result_rst", bsm_pkg::OFS_RESULT, 32'h0);
        rd_chk("status_comm", bsm_pkg::OFS_STATUS, 32'h8);
        apb_xfer(1'b1, 8'h10, 32'h1);
        check("unmapped", 32'h1, {31'h0, rd_err});
        apb_xfer(1'b1, bsm_pkg::OFS_GLOBAL, 32'h1);
        rd_chk("global", bsm_pkg::OFS_GLOBAL, 32'h1);
        for (int i = 0; i < 7; i++) begin
            seen_bp = 3'h0;
            seen_foot = 1'b0;
            seen_gain = 2'h0;
            seen_wide = 1'b0;
            seen_short = 1'b0;
            seen_res = 4'h0;
            seen_mux = 3'h0;
            apb_xfer(1'b1, bsm_pkg::OFS_SETUP, {24'h0, setups[i]});
            @(posedge pclk);
            #1;
            check("busy", 32'h1, {31'h0, sdo_level});
            check("op_active", 32'h2, {29'h0, op_state});
            check("rc_osc", 32'h1, {31'h0, rc_osc_en});
            // a write while busy must not touch the setup
            apb_xfer(1'b1, bsm_pkg::OFS_SETUP, 32'hff);
            while (sdo_level !== 1'b0) @(posedge pclk);
            @(posedge pclk);
            #1;
            check("idle_off", 32'h0, {27'h0, bridge_power, analog_en, rc_osc_en});
            check("idle_state", 32'h1, {29'h0, op_state});
            check("steering", {20'h0, steer[i]},
                {20'h0, seen_bp, seen_foot, seen_gain, seen_wide, seen_short,
                seen_res});
            check("mux", (steer[i] != 12'h0) ? {29'h0, 1'b1, setups[i][5:4]} : 32'h0,
                {29'h0, seen_mux});
            rd_chk("setup_clr", bsm_pkg::OFS_SETUP, {24'h0, setups[i] & 8'hfe});
            rd_chk("result", bsm_pkg::OFS_RESULT,
                (steer[i] != 12'h0) ? 32'h5a00 + SAMPLES : 32'h5a00);
        end
        end_of_test();
    end

    // well under a thousand bus cycles; this is many times that
    initial begin
        #50000;
        num_errors++;
        end_of_test();
    end
endmodule
